/* File: design/tcoc_defines.svh */
// constants for the tachometer compare and output control block
// assumes a 50 MHz core clock; included by the top module
`ifndef TCOC_DEFINES_SVH
`define TCOC_DEFINES_SVH

`define TCOC_CLK_HZ        50000000
`define TCOC_GATE_1S_MS    1000
`define TCOC_GATE_200_MS   200
`define TCOC_GATE_10_MS    10
`define TCOC_OFF_GAP_MS    20
`define TCOC_KEY_HOLD_MS   1000
`define TCOC_MS_CYC        (`TCOC_CLK_HZ / 1000)
`define TCOC_CEIL_MIN      24'h000001
`define TCOC_CEIL_MAX      24'h0F423F
`define TCOC_CEIL_RST      24'h0F423F
`define TCOC_ALARM_MAX     14'h270F
`define TCOC_ONCNT_UNIT    10'h3E8
`define TCOC_PROT_LEVELS   3'h7

`endif

/* File: design/tcoc_pkg.sv */
// types for the tachometer compare and output control block
// assumes tcoc_defines.svh for numeric constants
package tcoc_pkg;
	typedef enum logic [2:0] {
		TCOC_RUN  = 3'b001,
		TCOC_ARM  = 3'b010,
		TCOC_CFG  = 3'b100
	} tcoc_mode_t;

	typedef enum logic [1:0] {
		TCOC_PRESET_1 = 2'h0,
		TCOC_PRESET_2 = 2'h1,
		TCOC_TACHO    = 2'h2
	} tcoc_conf_t;
endpackage : tcoc_pkg

/* File: design/tcoc_top.sv */
// tachometer measurement, comparison and output control
// assumes synchronous pulse input, keys and switches; registers on a plain strobe port
//
// Operation
// - hysteresis in measured units stops chatter
// - off delay postpones output turning off
// - measurement continues while off delay holds
// - reject setpoint above ceiling; ceiling 1..999999
// - allocation flag swaps stage to output routing, except in the single-stage preset
// - mode selects pulse-cycle or pulse-width measurement
// - width mode holds last width without pulses
// - cycle mode shows hertz or period
// - counting interval 200 ms or continuous 10 ms
// - alarm threshold 0..9999 thousands; zero disables
// - count over threshold raises count error
// - on-count monitor read-only, count divided by 1000
// - config entry clears value, outputs off, stops
// - config applies on run return; reinit setpoints when the layout changed
// - config entry: key b held 1 s after a
// - reset default single-stage preset; two-stage variant
// - dip monitor shows switches only when enabled
// - hold freezes displayed value and outputs
// - key protect blocks the one key chosen by protect level, none at level 0; lights indicator
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "tcoc_defines.svh"

module tcoc_top #(
	parameter int  VAL_W       = 24,
	parameter bit  TWO_STAGE   = 1'b0,
	parameter int  GATE_1S_CYC = `TCOC_GATE_1S_MS * `TCOC_MS_CYC,
	parameter int  GATE_200_CYC = `TCOC_GATE_200_MS * `TCOC_MS_CYC,
	parameter int  GATE_10_CYC = `TCOC_GATE_10_MS * `TCOC_MS_CYC,
	parameter int  KEY_HOLD_CYC = `TCOC_KEY_HOLD_MS * `TCOC_MS_CYC,
	parameter int  MS_CYC      = `TCOC_MS_CYC
) (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic              pulse_in,
	input  wire logic              hold_in,
	input  wire logic              key_a,
	input  wire logic              key_b,
	input  wire logic              key_exit,
	input  wire logic [7:0]        dip_sw,
	input  wire logic              key_protect_sw,
	input  wire logic [2:0]        protect_level,
	input  wire logic [3:0]        op_keys,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	output logic                   first_output,
	output logic                   second_output,
	output logic      [VAL_W-1:0]  display_value,
	output logic                   count_error,
	output logic                   protect_led,
	output logic      [3:0]        op_keys_ok,
	output logic      [7:0]        dip_monitor,
	output logic                   cfg_mode
);
	localparam int CNT_W = 32;

	// register offsets (byte addresses)
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_SP1   = 8'h04;
	localparam logic [7:0] A_SP2   = 8'h08;
	localparam logic [7:0] A_CEIL  = 8'h0C;
	localparam logic [7:0] A_HYST  = 8'h10;
	localparam logic [7:0] A_OFFD  = 8'h14;
	localparam logic [7:0] A_ALM1  = 8'h18;
	localparam logic [7:0] A_ALM2  = 8'h1C;
	localparam logic [7:0] A_MON1  = 8'h20;
	localparam logic [7:0] A_MON2  = 8'h24;
	localparam logic [7:0] A_STAT  = 8'h28;
	localparam logic [7:0] A_CONF  = 8'h2C;

	// control fields: bit0 width mode, bit1 period unit, bit2 continuous, bit3 swap
	logic              width_mode;
	logic              unit_period;
	logic              gate_cont;
	logic              swap_out;
	logic [VAL_W-1:0]  stage_one_setpoint;
	logic [VAL_W-1:0]  stage_two_setpoint;
	logic [VAL_W-1:0]  setpoint_ceiling;
	logic [VAL_W-1:0]  hyst;
	logic [15:0]       off_delay_ms;
	logic [13:0]       alarm1;
	logic [13:0]       alarm2;
	logic [1:0]        conf_act;
	logic [1:0]        conf_pend;
	logic              conf_dirty;
	tcoc_pkg::tcoc_mode_t mode;

	logic              pulse_d;
	logic              rise;
	logic              fall;
	logic [CNT_W-1:0]  gate_cnt;
	logic [CNT_W-1:0]  edge_cnt;
	logic [CNT_W-1:0]  edges_now;
	logic [CNT_W-1:0]  width_cnt;
	logic [VAL_W-1:0]  meas;
	logic              running;
	logic              hold_q;
	logic [CNT_W-1:0]  gate_len;
	logic [VAL_W-1:0]  gate_scale;

	assign running  = (mode != tcoc_pkg::TCOC_CFG);
	assign hold_q   = hold_in;
	assign rise     = pulse_in & ~pulse_d;
	assign fall     = ~pulse_in & pulse_d;
	// edges including this cycle, so a rise on the last gate cycle is not lost
	assign edges_now = edge_cnt + CNT_W'(rise);
	assign gate_len = gate_cont ? CNT_W'(GATE_10_CYC) : CNT_W'(GATE_200_CYC);
	// scale to pulses per second for the chosen interval
	assign gate_scale = gate_cont ? VAL_W'(100) : VAL_W'(5);

	// register writes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			width_mode         <= 1'b0;
			unit_period        <= 1'b0;
			gate_cont          <= 1'b0;
			swap_out           <= 1'b0;
			stage_one_setpoint <= '0;
			stage_two_setpoint <= '0;
			setpoint_ceiling   <= VAL_W'(`TCOC_CEIL_RST);
			hyst               <= '0;
			off_delay_ms       <= '0;
			alarm1             <= '0;
			alarm2             <= '0;
			conf_pend          <= TWO_STAGE ? 2'(tcoc_pkg::TCOC_PRESET_2)
			                                : 2'(tcoc_pkg::TCOC_PRESET_1);
		end else if (mode == tcoc_pkg::TCOC_CFG && key_exit && conf_pend != conf_act) begin
			// leaving config with a new layout wins over a write in that cycle
			stage_one_setpoint <= '0;
			stage_two_setpoint <= '0;
		end else if (reg_wr) begin
			if (reg_addr == A_CTRL) begin
				width_mode  <= reg_wdata[0];
				unit_period <= reg_wdata[1];
				gate_cont   <= reg_wdata[2];
				swap_out    <= reg_wdata[3];
			end else if (reg_addr == A_SP1) begin
				if (reg_wdata[VAL_W-1:0] <= setpoint_ceiling)
					stage_one_setpoint <= reg_wdata[VAL_W-1:0];
			end else if (reg_addr == A_SP2) begin
				if (reg_wdata[VAL_W-1:0] <= setpoint_ceiling)
					stage_two_setpoint <= reg_wdata[VAL_W-1:0];
			end else if (reg_addr == A_CEIL) begin
				if (reg_wdata[VAL_W-1:0] >= VAL_W'(`TCOC_CEIL_MIN) &&
				    reg_wdata[VAL_W-1:0] <= VAL_W'(`TCOC_CEIL_MAX))
					setpoint_ceiling <= reg_wdata[VAL_W-1:0];
			end else if (reg_addr == A_HYST) begin
				hyst <= reg_wdata[VAL_W-1:0];
			end else if (reg_addr == A_OFFD) begin
				off_delay_ms <= reg_wdata[15:0];
			end else if (reg_addr == A_ALM1) begin
				if (reg_wdata[13:0] <= `TCOC_ALARM_MAX)
					alarm1 <= reg_wdata[13:0];
			end else if (reg_addr == A_ALM2) begin
				if (reg_wdata[13:0] <= `TCOC_ALARM_MAX)
					alarm2 <= reg_wdata[13:0];
			end else if (reg_addr == A_CONF && mode == tcoc_pkg::TCOC_CFG) begin
				conf_pend <= reg_wdata[3:2]; // pending code sits above the active one
			end
		end
	end

	// config key sequence: a first, then b held 1 s
	logic [CNT_W-1:0] key_cnt;
	logic             key_b_d;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode     <= tcoc_pkg::TCOC_RUN;
			key_cnt  <= '0;
			key_b_d  <= 1'b0;
			conf_act <= TWO_STAGE ? 2'(tcoc_pkg::TCOC_PRESET_2)
			                      : 2'(tcoc_pkg::TCOC_PRESET_1);
		end else begin
			key_b_d <= key_b;
			case (mode)
				tcoc_pkg::TCOC_RUN: begin
					key_cnt <= '0;
					if (key_a && key_b && !key_b_d)
						mode <= tcoc_pkg::TCOC_ARM;
				end
				tcoc_pkg::TCOC_ARM: begin
					if (!(key_a && key_b))
						mode <= tcoc_pkg::TCOC_RUN;
					else if (key_cnt >= CNT_W'(KEY_HOLD_CYC - 1))
						mode <= tcoc_pkg::TCOC_CFG;
					else
						key_cnt <= key_cnt + 1'b1;
				end
				tcoc_pkg::TCOC_CFG: begin
					if (key_exit) begin
						mode     <= tcoc_pkg::TCOC_RUN;
						conf_act <= conf_pend;
					end
				end
				default: mode <= tcoc_pkg::TCOC_RUN;
			endcase
		end
	end
	assign conf_dirty = (conf_pend != conf_act);

	// measurement: counts keep running during off delay
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pulse_d   <= 1'b0;
			gate_cnt  <= '0;
			edge_cnt  <= '0;
			width_cnt <= '0;
			meas      <= '0;
		end else if (!running) begin
			pulse_d   <= pulse_in;
			gate_cnt  <= '0;
			edge_cnt  <= '0;
			width_cnt <= '0;
			meas      <= '0;
		end else begin
			pulse_d <= pulse_in;
			if (width_mode) begin
				// width in ms; last width stays without pulses
				if (pulse_in)
					width_cnt <= width_cnt + 1'b1;
				if (fall)
					meas <= VAL_W'(width_cnt / CNT_W'(MS_CYC));
				// the rise cycle is already the first on cycle
				if (rise)
					width_cnt <= CNT_W'(1);
			end else begin
				if (gate_cnt >= gate_len - 1'b1) begin
					gate_cnt <= '0;
					edge_cnt <= '0;
					if (unit_period)
						meas <= (edges_now == 0) ? '0
						      : VAL_W'(gate_len / (edges_now * CNT_W'(MS_CYC)));
					else
						meas <= VAL_W'(edges_now) * gate_scale;
				end else begin
					gate_cnt <= gate_cnt + 1'b1;
					edge_cnt <= edge_cnt + CNT_W'(rise);
				end
			end
		end
	end

	// compare with hysteresis and off delay per stage
	logic [1:0]       stage_on;
	logic [1:0]       cmp_raw;
	logic [CNT_W-1:0] offd_cnt [2];
	logic [VAL_W-1:0] sp [2];
	assign sp[0] = stage_one_setpoint;
	assign sp[1] = stage_two_setpoint;

	for (genvar s = 0; s < 2; s++) begin : g_stage
		always_ff @(posedge core_clk) begin
			if (srst || !running) begin
				cmp_raw[s]  <= 1'b0;
				stage_on[s] <= 1'b0;
				offd_cnt[s] <= '0;
			end else if (!hold_q) begin
				if (meas >= sp[s])
					cmp_raw[s] <= 1'b1;
				else if (meas + hyst < sp[s])
					cmp_raw[s] <= 1'b0;
				if (cmp_raw[s]) begin
					stage_on[s] <= 1'b1;
					offd_cnt[s] <= '0;
				end else if (stage_on[s]) begin
					if (offd_cnt[s] >= CNT_W'(off_delay_ms) * CNT_W'(MS_CYC))
						stage_on[s] <= 1'b0;
					else
						offd_cnt[s] <= offd_cnt[s] + 1'b1;
				end
			end
		end
	end

	// output routing, display freeze, on counters
	logic [CNT_W-1:0] on_cnt [2];
	logic [1:0]       out_prev;
	logic [1:0]       out_now;
	assign out_now = (conf_act == 2'(tcoc_pkg::TCOC_PRESET_1))
	               ? {1'b0, stage_on[0]}
	               : (swap_out ? {stage_on[0], stage_on[1]} : stage_on);

	always_ff @(posedge core_clk) begin
		if (srst || !running) begin
			first_output  <= 1'b0;
			second_output <= 1'b0;
			display_value <= '0;
		end else if (!hold_q) begin
			first_output  <= out_now[0];
			second_output <= out_now[1];
			display_value <= meas;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			out_prev  <= '0;
			on_cnt[0] <= '0;
			on_cnt[1] <= '0;
		end else begin
			out_prev <= {second_output, first_output};
			if (first_output && !out_prev[0])
				on_cnt[0] <= on_cnt[0] + 1'b1;
			if (second_output && !out_prev[1])
				on_cnt[1] <= on_cnt[1] + 1'b1;
		end
	end

	// alarm, protect, dip monitor, config flag
	always_ff @(posedge core_clk) begin
		if (srst) begin
			count_error <= 1'b0;
			protect_led <= 1'b0;
			op_keys_ok  <= '0;
			dip_monitor <= '0;
			cfg_mode    <= 1'b0;
		end else begin
			count_error <= (alarm1 != 0 && on_cnt[0] > alarm1 * CNT_W'(`TCOC_ONCNT_UNIT)) ||
			               (alarm2 != 0 && on_cnt[1] > alarm2 * CNT_W'(`TCOC_ONCNT_UNIT));
			protect_led <= key_protect_sw;
			if (key_protect_sw && protect_level != 3'h0 && protect_level <= `TCOC_PROT_LEVELS)
				op_keys_ok <= op_keys & ~(4'h1 << (protect_level[1:0]));
			else
				op_keys_ok <= op_keys;
			dip_monitor <= dip_sw[0] ? dip_sw : 8'h00;
			cfg_mode    <= (mode == tcoc_pkg::TCOC_CFG);
		end
	end

	// register reads, data one cycle after strobe
	always_ff @(posedge core_clk) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (reg_addr == A_CTRL)
				reg_rdata <= {28'h0, swap_out, gate_cont, unit_period, width_mode};
			else if (reg_addr == A_SP1)
				reg_rdata <= 32'(stage_one_setpoint);
			else if (reg_addr == A_SP2)
				reg_rdata <= 32'(stage_two_setpoint);
			else if (reg_addr == A_CEIL)
				reg_rdata <= 32'(setpoint_ceiling);
			else if (reg_addr == A_HYST)
				reg_rdata <= 32'(hyst);
			else if (reg_addr == A_OFFD)
				reg_rdata <= {16'h0, off_delay_ms};
			else if (reg_addr == A_ALM1)
				reg_rdata <= {18'h0, alarm1};
			else if (reg_addr == A_ALM2)
				reg_rdata <= {18'h0, alarm2};
			else if (reg_addr == A_MON1)
				reg_rdata <= on_cnt[0] / 32'(`TCOC_ONCNT_UNIT);
			else if (reg_addr == A_MON2)
				reg_rdata <= on_cnt[1] / 32'(`TCOC_ONCNT_UNIT);
			else if (reg_addr == A_STAT)
				reg_rdata <= {26'h0, conf_dirty, count_error, second_output,
				              first_output, cfg_mode, hold_q};
			else if (reg_addr == A_CONF)
				reg_rdata <= {28'h0, conf_pend, conf_act};
			else
				reg_rdata <= 32'h0000_0000;
		end
	end
endmodule : tcoc_top

/* File: tb/tcoc_chk_asserts.sv */
// port assertions for the tachometer compare and output block
// assumes a bind from the bench top; one clock domain
`timescale 1ns/100ps
module tcoc_chk #(
	parameter int VAL_W = 24
) (
	input wire logic             core_clk,
	input wire logic             srst,
	input wire logic             hold_in,
	input wire logic             key_a,
	input wire logic             key_b,
	input wire logic [7:0]       dip_sw,
	input wire logic             key_protect_sw,
	input wire logic [3:0]       op_keys,
	input wire logic [7:0]       reg_addr,
	input wire logic             reg_rd,
	input wire logic [31:0]      reg_rdata,
	input wire logic             first_output,
	input wire logic             second_output,
	input wire logic [VAL_W-1:0] display_value,
	input wire logic             protect_led,
	input wire logic [3:0]       op_keys_ok,
	input wire logic [7:0]       dip_monitor,
	input wire logic             cfg_mode
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	// hold input seen on two edges in a row
	sequence s_hold2;
		hold_in ##1 hold_in;
	endsequence

	// switch monitor, protect indicator and key gate
	a_dip_gate: assert property (!dip_sw[0] |=> dip_monitor == 8'h00)
		else $error("dip monitor shown while disabled");
	a_led_prot: assert property (1'b1 |=> protect_led == $past(key_protect_sw))
		else $error("protect led wrong");
	a_keys_pass: assert property (!key_protect_sw |=> op_keys_ok == $past(op_keys))
		else $error("keys blocked without protect");
	// hold freezes value and outputs
	a_hold_frz: assert property (s_hold2 ##1 hold_in |=> $stable(display_value)
		&& $stable(first_output) && $stable(second_output))
		else $error("value moved under hold");
	// config mode entry and its quiet state
	a_cfg_quiet: assert property (cfg_mode [*3] |-> !first_output && !second_output
		&& display_value == '0)
		else $error("outputs alive in config mode");
	a_cfg_chord: assert property ($rose(cfg_mode) |-> $past(key_a, 2) && $past(key_b, 2))
		else $error("config entered without both keys");
	// register contents stay within their limits
	a_ceil_rng: assert property (reg_rd && reg_addr == 8'h0C |=>
		reg_rdata inside {[32'h1:32'h000F423F]})
		else $error("ceiling out of range");
	a_alm_rng: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata <= 32'h270F)
		else $error("alarm threshold out of range");
endmodule : tcoc_chk

/* File: tb/tcoc_pulse_src.sv */
// pulse sensor model driving the measured input
// assumes callers start on a rising clock edge
`timescale 1ns/100ps
module tcoc_pulse_src #(
	parameter int GAP_CYC = 25
) (
	input  wire logic core_clk,
	output logic      pulse_in
);
	initial pulse_in = 1'b0;

	// one on pulse, then the off gap width mode needs
	task automatic send(input int w);
		@(posedge core_clk) pulse_in <= 1'b1;
		repeat (w) @(posedge core_clk);
		pulse_in <= 1'b0;
		repeat (GAP_CYC) @(posedge core_clk);
	endtask : send

	// free running train for cycle mode: 5 on, 5 off, n periods
	task automatic run(input int n);
		repeat (n) begin
			@(posedge core_clk) pulse_in <= 1'b1;
			repeat (5) @(posedge core_clk);
			pulse_in <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
	endtask : run
endmodule : tcoc_pulse_src

/* File: tb/tcoc_top_tb_top.sv */
// bench top for the tachometer compare and output block
// assumes shortened gates, 20 cycle key hold and 1 cycle per ms
`timescale 1ns/100ps
module tcoc_top_tb_top;
	logic        core_clk       = 1'b0;
	logic        srst           = 1'b1;
	logic        hold_in        = 1'b0;
	logic        key_a          = 1'b0;
	logic        key_b          = 1'b0;
	logic        key_exit       = 1'b0;
	logic [7:0]  dip_sw         = 8'h00;
	logic        key_protect_sw = 1'b0;
	logic [2:0]  protect_level  = 3'h1;
	logic [3:0]  op_keys        = 4'h0;
	logic [7:0]  reg_addr       = 8'h00;
	logic [31:0] reg_wdata      = 32'h0;
	logic        reg_wr         = 1'b0;
	logic        reg_rd         = 1'b0;
	logic        pulse_in, first_output, second_output, count_error, protect_led, cfg_mode;
	logic [31:0] reg_rdata;
	logic [23:0] display_value;
	logic [3:0]  op_keys_ok;
	logic [7:0]  dip_monitor;
	int          fail_count     = 0;
	int          n_tests        = 0;

	always #10 core_clk = ~core_clk;

	tcoc_top #(.GATE_200_CYC(200), .GATE_10_CYC(10),
		.KEY_HOLD_CYC(20), .MS_CYC(1)) i_tcoc_top (.*);
	tcoc_pulse_src i_tcoc_pulse_src (.core_clk(core_clk), .pulse_in(pulse_in));

	// compare, count and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	// wait edges, then settle at the falling edge
	task automatic go(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : go
	// register port cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk) reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk) reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk) reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk) reg_rd <= 1'b0;
		@(negedge core_clk) chk(reg_rdata, e);
	endtask : rd
	// one pulse, then check value and first output
	task automatic pulse(input int w, input logic [23:0] v, input logic o);
		i_tcoc_pulse_src.send(w);
		go(0);
		chk({first_output, display_value}, {o, v});
	endtask : pulse
	// first key, then second key held until config mode
	task automatic enter_cfg();
		int i;
		@(posedge core_clk) key_a <= 1'b1;
		go(2);
		@(posedge core_clk) key_b <= 1'b1;
		go(10);
		chk(cfg_mode, 1'b0);
		for (i = 0; i < 60 && cfg_mode !== 1'b1; i++)
			go(1);
		chk(cfg_mode, 1'b1);
		@(posedge core_clk) {key_a, key_b} <= 2'b00;
		go(1);
	endtask : enter_cfg

	// cut a hung run short
	initial begin
		repeat (6000) @(posedge core_clk);
		fail_count++;
		report_and_stop();
	end

	// main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		rd(8'h0C, 32'h000F423F);
		rd(8'h2C, 32'h0);
		wr(8'h0C, 32'h0);
		wr(8'h0C, 32'h000F4240);
		rd(8'h0C, 32'h000F423F);
		wr(8'h0C, 32'h64);
		wr(8'h04, 32'h64);
		wr(8'h04, 32'h65);
		rd(8'h04, 32'h64);
		wr(8'h18, 32'h2710);
		rd(8'h18, 32'h0);
		wr(8'h18, 32'h270F);
		rd(8'h18, 32'h270F);
		wr(8'h20, 32'h5);
		rd(8'h20, 32'h0);
		wr(8'h2C, 32'h8);
		rd(8'h2C, 32'h0);
		rd(8'h40, 32'h0);
		@(posedge core_clk) dip_sw <= 8'hA4;
		go(2);
		chk(dip_monitor, 8'h00);
		@(posedge core_clk) dip_sw <= 8'hA5;
		op_keys <= 4'hF;
		go(2);
		chk({dip_monitor, op_keys_ok}, 12'hA5F);
		@(posedge core_clk) key_protect_sw <= 1'b1;
		protect_level <= 3'h2;
		go(2);
		chk({protect_led, op_keys_ok}, 5'h1B);
		@(posedge core_clk) key_b <= 1'b1;
		go(2);
		@(posedge core_clk) key_a <= 1'b1;
		go(40);
		chk(cfg_mode, 1'b0);
		@(posedge core_clk) {key_a, key_b} <= 2'b00;
		enter_cfg();
		wr(8'h2C, 32'h8);
		@(posedge core_clk) key_exit <= 1'b1;
		@(posedge core_clk) key_exit <= 1'b0;
		go(3);
		rd(8'h2C, 32'hA);
		rd(8'h04, 32'h0);
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h14);
		wr(8'h08, 32'h60);
		wr(8'h10, 32'h5);
		pulse(30, 24'h1E, 1'b1);
		pulse(17, 24'h11, 1'b1);
		pulse(10, 24'h0A, 1'b0);
		go(40);
		chk(display_value, 24'h0A);
		wr(8'h14, 32'h32);
		pulse(30, 24'h1E, 1'b1);
		pulse(10, 24'h0A, 1'b1);
		go(40);
		chk(first_output, 1'b0);
		wr(8'h14, 32'h0);
		pulse(30, 24'h1E, 1'b1);
		wr(8'h00, 32'h9);
		go(3);
		chk({first_output, second_output}, 2'b01);
		@(posedge core_clk) hold_in <= 1'b1;
		go(2);
		i_tcoc_pulse_src.send(10);
		go(1);
		chk({second_output, display_value}, {1'b1, 24'h1E});
		rd(8'h28, 32'h9);
		@(posedge core_clk) hold_in <= 1'b0;
		go(2);
		// cycle mode, 10 cycle period: 100 Hz on the long gate
		wr(8'h00, 32'h0);
		i_tcoc_pulse_src.run(80);
		go(0);
		chk(display_value, 24'h64);
		// period unit on the continuous gate: 10 ms
		wr(8'h00, 32'h6);
		i_tcoc_pulse_src.run(20);
		go(0);
		chk(display_value, 24'h0A);
		enter_cfg();
		chk({first_output, second_output, display_value}, 26'h0);
		report_and_stop();
	end
endmodule : tcoc_top_tb_top

bind tcoc_top tcoc_chk #(.VAL_W(VAL_W)) i_tcoc_chk (.*);
